//--- include/regfault_pkg.sv
package regfault_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hc;

	// Control and status fields
	localparam int CTL_UV_EN_BIT = 0;
	localparam logic UV_EN_RST = 1'b1;
	localparam int STS_STATE_LSB = 0;
	localparam int STS_FLAG_BIT = 4;
	localparam int STS_CNT_LSB = 8;
	localparam int STS_HOT_BIT = 16;
	localparam int STS_GATE_BIT = 17;

	// Interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_OC = 0;
	localparam int IRQ_UV = 1;
	localparam int IRQ_HOT = 2;
	localparam int IRQ_RESTART = 3;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam logic [3:0] IRQ_STATUS_RST = 4'h0;

	// ------------------------------------------------------------
	// Fault counting
	// ------------------------------------------------------------
	localparam int CNT_W = 5;
	localparam logic [4:0] OC_CNT_RST = 5'h00;
	localparam logic [4:0] OC_CNT_FIRST = 5'h01;
	localparam logic [4:0] OC_RUN_LIMIT = 5'h10;
	localparam logic [4:0] OC_FAULT_AT = 5'h0f;
	localparam logic [4:0] OC_FLAG_LIMIT = 5'h04;
	localparam int HIC_W = 3;
	localparam logic [2:0] HIC_CNT_RST = 3'h0;
	localparam logic [2:0] HICCUP_PERIODS = 3'h4;
	localparam logic [2:0] HICCUP_LAST = 3'h3;

	// ------------------------------------------------------------
	// Pin synchroniser lanes
	// ------------------------------------------------------------
	localparam int SYNC_W = 7;
	localparam int PIN_EN_N = 0;
	localparam int PIN_OC = 1;
	localparam int PIN_UV = 2;
	localparam int PIN_HOT = 3;
	localparam int PIN_COOL = 4;
	localparam int PIN_RAMP = 5;
	localparam int PIN_SSDONE = 6;
	localparam logic [6:0] SYNC_RST = 7'h01;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SOFTSTART = 3'b001,
		ST_RUN = 3'b010,
		ST_HICCUP = 3'b011,
		ST_HOT = 3'b100
	} state_t;

endpackage

//--- logic/pin_sync.sv
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i, // Sampling clock
	input wire logic rst_i, // Sync reset, high
	input wire logic [WIDTH-1:0] d_i, // Asynchronous inputs
	output logic [WIDTH-1:0] q_o // Synchronised outputs
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stab_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			stab_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			stab_r <= meta_r;
		end
	end

	assign q_o = stab_r;

endmodule

//--- logic/regulator_fault_hiccup_control.sv
// How it works
// RULE_01: Overcurrent cuts switch until next cycle.
// RULE_02: First overcurrent: counter one, flag high.
// RULE_03: Consecutive overcurrent cycle increments counter.
// RULE_04: Sixteen consecutive overcurrents: stop, fault.
// RULE_05: Overcurrent fault waits four soft-start periods.
// RULE_06: Hiccup end clears counters, restarts soft-start.
// RULE_07: Overcurrent gone below four: flag low.
// RULE_08: Flag high, count below four, undervoltage: shutdown.
// RULE_09: Undervoltage with flag low: undervoltage fault.
// RULE_10: Undervoltage fault waits four soft-start periods.
// RULE_11: Off at 150 C until below 135.
// RULE_12: Enable pin high shuts everything down.
// RULE_13: Enable going low reruns full start-up.
// RULE_14: Counter and flag update at ramp end.
// RULE_15: Disabled: counters clear, flag low, switch off.
module regulator_fault_hiccup_control (
	input wire logic mclk_i, // 100 MHz clock
	input wire logic rst_i, // Sync reset, high
	input wire logic enable_n_i, // Enable pin, low active
	input wire logic over_current_i, // Switch current comparator
	input wire logic uv_detect_i, // Feedback_sense 14% low
	input wire logic temp_hot_i, // Junction at 150 C
	input wire logic temp_cool_i, // Junction below 135 C
	input wire logic ramp_end_i, // Oscillator ramp end
	input wire logic ss_done_i, // Soft-start period ended
	input wire logic [regfault_pkg::ADDR_W-1:0] avs_address_i, // Byte addr
	input wire logic avs_read_i, // Bus read
	input wire logic avs_write_i, // Bus write
	input wire logic [31:0] avs_writedata_i, // Write data
	input wire logic [3:0] avs_byteenable_i, // Byte lanes
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Bus stall
	output logic gate_en_o, // High-side gate enable
	output logic ss_request_o, // Start soft-start ramp
	output logic irq_o // Interrupt, level
);
	import regfault_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisation and edges
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins_s;
	logic ramp_d_r;
	logic ss_d_r;
	logic ramp_tick;
	logic ss_tick;

	assign pins_raw = {ss_done_i, ramp_end_i, temp_cool_i, temp_hot_i,
		uv_detect_i, over_current_i, enable_n_i};

	// Reset value keeps the enable pin reading inactive
	pin_sync #(
		.WIDTH(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.d_i(pins_raw),
		.q_o(pins_s)
	);

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ramp_d_r <= 1'b0;
			ss_d_r <= 1'b0;
		end else begin
			ramp_d_r <= pins_s[PIN_RAMP];
			ss_d_r <= pins_s[PIN_SSDONE];
		end
	end

	assign ramp_tick = pins_s[PIN_RAMP] & ~ramp_d_r;
	assign ss_tick = pins_s[PIN_SSDONE] & ~ss_d_r;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	state_t state_r;
	state_t state_nxt;
	logic thermal_r;
	logic oc_cut_r;
	logic oc_cut_nxt;
	logic oc_flag_r;
	logic [CNT_W-1:0] oc_cnt_r;
	logic [HIC_W-1:0] hic_cnt_r;
	logic gate_en_r;
	logic ss_request_r;
	logic uv_en_r;
	logic [IRQ_W-1:0] irq_st_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic irq_r;
	logic waitreq_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic active;
	logic active_nxt;
	logic cycle_oc;
	logic oc_fault_evt;
	logic uv_evt;
	logic hiccup_done;
	logic count_clr;
	logic wr_go;
	logic rd_take;

	// ------------------------------------------------------------
	// Thermal shutdown with hysteresis
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			thermal_r <= 1'b0;
		else if (pins_s[PIN_HOT])
			thermal_r <= 1'b1; // [RULE_11]
		else if (pins_s[PIN_COOL])
			thermal_r <= 1'b0; // [RULE_11]
	end

	// ------------------------------------------------------------
	// Fault events
	// ------------------------------------------------------------
	// Switching is allowed only while soft-starting or running
	function automatic logic is_live(input state_t s);
		return (s == ST_SOFTSTART) || (s == ST_RUN);
	endfunction

	assign active = is_live(state_r);
	assign active_nxt = is_live(state_nxt);
	assign cycle_oc = oc_cut_r | pins_s[PIN_OC];
	assign oc_fault_evt = active & ramp_tick & cycle_oc &
		(oc_cnt_r == OC_FAULT_AT); // [RULE_04]
	// Blanked during soft-start: feedback is low by nature there
	assign uv_evt = (state_r == ST_RUN) & ramp_tick & pins_s[PIN_UV] &
		uv_en_r & (~oc_flag_r | (oc_cnt_r < OC_FLAG_LIMIT)); // [RULE_08] [RULE_09]
	assign hiccup_done = (state_r == ST_HICCUP) & ss_tick &
		(hic_cnt_r == HICCUP_LAST); // [RULE_05] [RULE_10]
	assign count_clr = (state_nxt == ST_OFF) || (state_nxt == ST_HOT) ||
		hiccup_done; // [RULE_06] [RULE_15]

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		if (pins_s[PIN_EN_N]) begin
			state_nxt = ST_OFF; // [RULE_12]
		end else if (thermal_r) begin
			state_nxt = ST_HOT; // [RULE_11]
		end else begin
			unique case (state_r)
				ST_OFF, ST_HOT: state_nxt = ST_SOFTSTART; // [RULE_13]
				ST_SOFTSTART: begin
					if (oc_fault_evt)
						state_nxt = ST_HICCUP; // [RULE_04]
					else if (ss_tick)
						state_nxt = ST_RUN;
				end
				ST_RUN: begin
					if (oc_fault_evt || uv_evt)
						state_nxt = ST_HICCUP; // [RULE_04] [RULE_09]
				end
				ST_HICCUP: begin
					if (hiccup_done)
						state_nxt = ST_SOFTSTART; // [RULE_06]
				end
				default: state_nxt = ST_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i)
			state_r <= ST_OFF;
		else
			state_r <= state_nxt;
	end

	// Hiccup wait counts soft-start periods with the switch off
	always_ff @(posedge mclk_i) begin
		if (rst_i || state_r != ST_HICCUP)
			hic_cnt_r <= HIC_CNT_RST;
		else if (ss_tick)
			hic_cnt_r <= hic_cnt_r + 3'h1; // [RULE_05] [RULE_10]
	end

	// One ramp per soft-start and per hiccup wait period
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			ss_request_r <= 1'b0;
		else
			ss_request_r <= (state_nxt == ST_SOFTSTART &&
				state_r != ST_SOFTSTART) || (state_nxt == ST_HICCUP &&
				(state_r != ST_HICCUP || ss_tick)); // [RULE_13] [RULE_06]
	end

	// ------------------------------------------------------------
	// Pulse-by-pulse cut and gate drive
	// ------------------------------------------------------------
	// Comparator latency is two clocks through the synchroniser, three to the gate
	assign oc_cut_nxt = active_nxt &
		(pins_s[PIN_OC] | (oc_cut_r & ~ramp_tick)); // [RULE_01]

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			oc_cut_r <= 1'b0;
			gate_en_r <= 1'b0;
		end else begin
			oc_cut_r <= oc_cut_nxt;
			gate_en_r <= active_nxt & ~oc_cut_nxt; // [RULE_01] [RULE_15]
		end
	end

	// ------------------------------------------------------------
	// Consecutive overcurrent counter and condition flag
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i || count_clr) begin
			oc_cnt_r <= OC_CNT_RST; // [RULE_15] [RULE_06]
			oc_flag_r <= 1'b0;
		end else if (active && ramp_tick) begin // [RULE_14]
			if (cycle_oc) begin
				if (oc_cnt_r == OC_CNT_RST) begin
					oc_cnt_r <= OC_CNT_FIRST; // [RULE_02]
					oc_flag_r <= 1'b1; // [RULE_02]
				end else begin
					oc_cnt_r <= oc_cnt_r + 5'h01; // [RULE_03]
				end
			end else begin
				// A clean cycle breaks the run
				oc_cnt_r <= OC_CNT_RST;
				if (oc_cnt_r < OC_FLAG_LIMIT)
					oc_flag_r <= 1'b0; // [RULE_07]
			end
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait state per access
	// ------------------------------------------------------------
	assign wr_go = avs_write_i & ~waitreq_r;
	assign rd_take = avs_read_i & waitreq_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i)
			waitreq_r <= 1'b1;
		else
			waitreq_r <= ~((avs_read_i | avs_write_i) & waitreq_r);
	end

	always_comb begin
		rdata_nxt = 32'h0;
		unique case (avs_address_i)
			OFS_CONTROL: rdata_nxt[CTL_UV_EN_BIT] = uv_en_r;
			OFS_STATUS: begin
				rdata_nxt[STS_STATE_LSB +: 3] = state_r;
				rdata_nxt[STS_FLAG_BIT] = oc_flag_r;
				rdata_nxt[STS_CNT_LSB +: CNT_W] = oc_cnt_r;
				rdata_nxt[STS_HOT_BIT] = thermal_r;
				rdata_nxt[STS_GATE_BIT] = gate_en_r;
			end
			OFS_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_st_r;
			OFS_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = irq_mask_r;
			default: rdata_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i)
			rdata_r <= 32'h0;
		else if (rd_take)
			rdata_r <= rdata_nxt;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			uv_en_r <= UV_EN_RST;
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_go && avs_byteenable_i[0]) begin
			if (avs_address_i == OFS_CONTROL)
				uv_en_r <= avs_writedata_i[CTL_UV_EN_BIT];
			if (avs_address_i == OFS_IRQ_MASK)
				irq_mask_r <= avs_writedata_i[IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Interrupts: sticky, write one to clear, set wins
	// ------------------------------------------------------------
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_OC] = oc_fault_evt;
		irq_set[IRQ_UV] = uv_evt;
		irq_set[IRQ_HOT] = pins_s[PIN_HOT] & ~thermal_r;
		irq_set[IRQ_RESTART] = hiccup_done;
	end

	assign irq_clr = (wr_go && avs_byteenable_i[0] &&
		avs_address_i == OFS_IRQ_STATUS) ? avs_writedata_i[IRQ_W-1:0] : '0;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_st_r <= IRQ_STATUS_RST;
			irq_r <= 1'b0;
		end else begin
			irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
			irq_r <= |(irq_st_r & irq_mask_r);
		end
	end

	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = waitreq_r;
	assign gate_en_o = gate_en_r;
	assign ss_request_o = ss_request_r;
	assign irq_o = irq_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_oc_cut;
		pins_s[PIN_OC] |=> !gate_en_r;
	endproperty
	a_oc_cut: assert property (p_oc_cut) // [RULE_01]
		else $error("gate on after overcurrent");

	property p_cut_holds;
		oc_cut_r && !ramp_tick |=> !gate_en_r && oc_cut_r == active;
	endproperty
	a_cut_holds: assert property (p_cut_holds) // [RULE_01]
		else $error("gate back on inside cycle");

	property p_first_oc;
		active_nxt && active && ramp_tick && cycle_oc &&
		oc_cnt_r == OC_CNT_RST && !hiccup_done
		|=> oc_cnt_r == OC_CNT_FIRST && oc_flag_r;
	endproperty
	a_first_oc: assert property (p_first_oc) // [RULE_02]
		else $error("first overcurrent not counted");

	property p_oc_inc;
		active_nxt && active && ramp_tick && cycle_oc &&
		oc_cnt_r != OC_CNT_RST |=> oc_cnt_r == $past(oc_cnt_r) + 5'h01;
	endproperty
	a_oc_inc: assert property (p_oc_inc) // [RULE_03]
		else $error("overcurrent count not incremented");

	property p_oc_fault;
		oc_fault_evt && !pins_s[PIN_EN_N] && !thermal_r
		|=> state_r == ST_HICCUP && oc_cnt_r == OC_RUN_LIMIT && !gate_en_r;
	endproperty
	a_oc_fault: assert property (p_oc_fault) // [RULE_04]
		else $error("no shutdown after sixteen overcurrents");

	property p_hiccup_len;
		state_r == ST_HICCUP && state_nxt == ST_SOFTSTART
		|-> hic_cnt_r == HICCUP_PERIODS - 3'h1 && ss_tick;
	endproperty
	a_hiccup_len: assert property (p_hiccup_len) // [RULE_05]
		else $error("hiccup wait not four periods");

	property p_restart;
		hiccup_done && !pins_s[PIN_EN_N] && !thermal_r
		|=> state_r == ST_SOFTSTART && oc_cnt_r == OC_CNT_RST &&
		!oc_flag_r && ss_request_r;
	endproperty
	a_restart: assert property (p_restart) // [RULE_06]
		else $error("hiccup end did not restart cleanly");

	property p_flag_low;
		active_nxt && active && ramp_tick && !cycle_oc &&
		oc_cnt_r < OC_FLAG_LIMIT |=> !oc_flag_r;
	endproperty
	a_flag_low: assert property (p_flag_low) // [RULE_07]
		else $error("flag stayed high");

	property p_uv_down;
		uv_evt && !pins_s[PIN_EN_N] && !thermal_r
		|=> state_r == ST_HICCUP ##1 !gate_en_r;
	endproperty
	a_uv_down: assert property (p_uv_down) // [RULE_08] [RULE_09] [RULE_10]
		else $error("undervoltage did not shut down");

	property p_thermal;
		thermal_r |=> !gate_en_r;
	endproperty
	a_thermal: assert property (p_thermal) // [RULE_11]
		else $error("switching while hot");

	property p_disabled;
		pins_s[PIN_EN_N] |=> state_r == ST_OFF && !gate_en_r &&
		oc_cnt_r == OC_CNT_RST && !oc_flag_r;
	endproperty
	a_disabled: assert property (p_disabled) // [RULE_12] [RULE_15]
		else $error("not idle while disabled");

	property p_start;
		state_r == ST_OFF && !pins_s[PIN_EN_N] && !thermal_r
		|=> state_r == ST_SOFTSTART && ss_request_r;
	endproperty
	a_start: assert property (p_start) // [RULE_13]
		else $error("no soft-start on enable");

	property p_cnt_timing;
		$changed(oc_cnt_r) |-> $past(ramp_tick) || $past(count_clr);
	endproperty
	a_cnt_timing: assert property (p_cnt_timing) // [RULE_14]
		else $error("counter moved off ramp end");

	c_oc_fault: cover property (oc_fault_evt);
	c_uv_fault: cover property (uv_evt);
	c_hiccup_done: cover property (hiccup_done);
	c_thermal: cover property (thermal_r ##1 !thermal_r);

endmodule

//--- tb/regulator_fault_hiccup_control_bench.sv
module regulator_fault_hiccup_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import regfault_pkg::*;

	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic enable_n_i = 1'b1;
	logic over_current_i = 1'b0;
	logic uv_detect_i = 1'b0;
	logic temp_hot_i = 1'b0;
	logic temp_cool_i = 1'b1;
	logic ramp_end_i = 1'b0;
	logic ss_done_i = 1'b0;
	logic [ADDR_W-1:0] avs_address_i = '0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic gate_en_o;
	logic ss_request_o;
	logic irq_o;
	int miscompares = 0;
	int n_compared = 0;
	int n_ss = 0;
	int n0;
	logic [31:0] rd;

	regulator_fault_hiccup_control dut_u (
		.mclk_i(mclk_i), .rst_i(rst_i), .enable_n_i(enable_n_i),
		.over_current_i(over_current_i), .uv_detect_i(uv_detect_i),
		.temp_hot_i(temp_hot_i), .temp_cool_i(temp_cool_i),
		.ramp_end_i(ramp_end_i), .ss_done_i(ss_done_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .gate_en_o(gate_en_o),
		.ss_request_o(ss_request_o), .irq_o(irq_o)
	);

	initial begin
		forever #5 mclk_i = ~mclk_i;
	end

	// Soft-start requests are one-cycle pulses, so tally them
	always @(posedge mclk_i) begin
		if (ss_request_o === 1'b1) n_ss <= n_ss + 1;
	end

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("Compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ------------------------------------------------------------
	// Bus and pin tasks
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] wd);
		int i;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= wd;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (i == 50) begin
			miscompares++;
			end_of_test();
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check_word(rd, exp);
	endtask

	// State, flag and count fields only
	task automatic st_chk(input state_t s, input logic f,
		input logic [4:0] c);
		bus(1'b0, OFS_STATUS, 32'h0);
		check_word(rd & 32'h00001f17, {19'h0, c, 3'h0, f, 1'b0, s});
	endtask

	task automatic sv_chk(input state_t s);
		bus(1'b0, OFS_STATUS, 32'h0);
		check_word(rd & 32'h00000007, {29'h0, s});
	endtask

	task automatic wait_gate(input logic v);
		int i;
		for (i = 0; i < 20; i++) begin
			if (gate_en_o === v) break;
			@(posedge mclk_i);
		end
		check_bit(gate_en_o, v);
		if (i == 20) end_of_test();
	endtask

	// Held several clocks so the synchroniser sees each edge
	task automatic tick();
		@(posedge mclk_i);
		ramp_end_i <= 1'b1;
		cyc(3);
		ramp_end_i <= 1'b0;
		cyc(4);
	endtask

	task automatic ssd(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			ss_done_i <= 1'b1;
			cyc(3);
			ss_done_i <= 1'b0;
			cyc(4);
		end
	endtask

	task automatic oc_cyc(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			over_current_i <= 1'b1;
			cyc(4);
			over_current_i <= 1'b0;
			cyc(3);
			tick();
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		cyc(16);
		rst_i <= 1'b0;
		cyc(2);
		rd_chk(OFS_CONTROL, 32'h1);
		rd_chk(OFS_IRQ_MASK, 32'h0);
		rd_chk(OFS_IRQ_STATUS, 32'h0);
		bus(1'b1, OFS_STATUS, 32'hffffffff);
		st_chk(ST_OFF, 1'b0, 5'h00);
		bus(1'b1, 4'h2, 32'hffffffff);
		rd_chk(4'h2, 32'h0);
		check_bit(gate_en_o, 1'b0);
		n0 = n_ss;
		@(posedge mclk_i);
		enable_n_i <= 1'b0;
		wait_gate(1'b1);
		cyc(1);
		check_word(n_ss - n0, 32'd1);
		st_chk(ST_SOFTSTART, 1'b0, 5'h00);
		ssd(1);
		st_chk(ST_RUN, 1'b0, 5'h00);
		@(posedge mclk_i);
		over_current_i <= 1'b1;
		wait_gate(1'b0);
		over_current_i <= 1'b0;
		cyc(8);
		check_bit(gate_en_o, 1'b0);
		st_chk(ST_RUN, 1'b0, 5'h00);
		tick();
		rd_chk(OFS_STATUS, 32'h00020112);
		check_bit(gate_en_o, 1'b1);
		tick();
		st_chk(ST_RUN, 1'b0, 5'h00);
		oc_cyc(3);
		st_chk(ST_RUN, 1'b1, 5'h03);
		tick();
		st_chk(ST_RUN, 1'b0, 5'h00);
		// Flag high with count at four: undervoltage is not a fault
		oc_cyc(4);
		@(posedge mclk_i);
		uv_detect_i <= 1'b1;
		oc_cyc(1);
		st_chk(ST_RUN, 1'b1, 5'h05);
		uv_detect_i <= 1'b0;
		tick();
		st_chk(ST_RUN, 1'b1, 5'h00);
		n0 = n_ss;
		@(posedge mclk_i);
		uv_detect_i <= 1'b1;
		tick();
		uv_detect_i <= 1'b0;
		sv_chk(ST_HICCUP);
		check_bit(gate_en_o, 1'b0);
		rd_chk(OFS_IRQ_STATUS, 32'h2);
		ssd(3);
		sv_chk(ST_HICCUP);
		ssd(1);
		st_chk(ST_SOFTSTART, 1'b0, 5'h00);
		check_word(n_ss - n0, 32'd5);
		rd_chk(OFS_IRQ_STATUS, 32'ha);
		bus(1'b1, OFS_IRQ_STATUS, 32'hf);
		rd_chk(OFS_IRQ_STATUS, 32'h0);
		ssd(1);
		oc_cyc(15);
		st_chk(ST_RUN, 1'b1, 5'h0f);
		check_bit(irq_o, 1'b0);
		// Lane 0 disabled: the write must be dropped
		avs_byteenable_i <= 4'he;
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		avs_byteenable_i <= 4'hf;
		rd_chk(OFS_IRQ_MASK, 32'h0);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		rd_chk(OFS_IRQ_MASK, 32'h1);
		oc_cyc(1);
		st_chk(ST_HICCUP, 1'b1, 5'h10);
		check_bit(gate_en_o, 1'b0);
		check_bit(irq_o, 1'b1);
		bus(1'b1, OFS_IRQ_STATUS, 32'h1);
		cyc(2);
		check_bit(irq_o, 1'b0);
		ssd(3);
		sv_chk(ST_HICCUP);
		ssd(1);
		st_chk(ST_SOFTSTART, 1'b0, 5'h00);
		ssd(1);
		bus(1'b1, OFS_CONTROL, 32'h0);
		@(posedge mclk_i);
		uv_detect_i <= 1'b1;
		tick();
		sv_chk(ST_RUN);
		bus(1'b1, OFS_CONTROL, 32'h1);
		tick();
		uv_detect_i <= 1'b0;
		sv_chk(ST_HICCUP);
		check_bit(gate_en_o, 1'b0);
		ssd(5);
		@(posedge mclk_i);
		temp_cool_i <= 1'b0;
		temp_hot_i <= 1'b1;
		wait_gate(1'b0);
		temp_hot_i <= 1'b0;
		cyc(8);
		rd_chk(OFS_STATUS, 32'h00010004);
		rd_chk(OFS_IRQ_STATUS, 32'he);
		check_bit(gate_en_o, 1'b0);
		temp_cool_i <= 1'b1;
		wait_gate(1'b1);
		sv_chk(ST_SOFTSTART);
		ssd(1);
		oc_cyc(2);
		@(posedge mclk_i);
		enable_n_i <= 1'b1;
		wait_gate(1'b0);
		oc_cyc(1);
		st_chk(ST_OFF, 1'b0, 5'h00);
		check_bit(gate_en_o, 1'b0);
		n0 = n_ss;
		@(posedge mclk_i);
		enable_n_i <= 1'b0;
		wait_gate(1'b1);
		cyc(1);
		check_word(n_ss - n0, 32'd1);
		end_of_test();
	end

	// A hang counts as a failure
	initial begin
		#500000;
		miscompares++;
		end_of_test();
	end
endmodule
